// ### verilog/clb_pkg.sv
package clb_pkg;

  // ----------------------------------------
  // Geometry and timing
  // ----------------------------------------
  localparam int unsigned BUF_DEPTH    = 80;
  localparam int unsigned CODE_W       = 7;
  localparam int unsigned ENTRY_W      = 8;
  localparam int unsigned PAT_W        = 7;
  localparam int unsigned SHIFT_W      = 8;
  localparam int unsigned LINE_W       = 4;
  localparam logic [3:0]  LINE_LAST    = 4'h9;
  localparam logic [3:0]  LINE_FIRST   = 4'h0;
  localparam logic [2:0]  DOT_RD_LO    = 3'h2;
  localparam logic [2:0]  DOT_RD_HI    = 3'h7;
  localparam int unsigned BIT_CURSOR   = 7;
  localparam int unsigned BIT_PRINT_LO = 5;
  localparam int unsigned BIT_PRINT_HI = 6;
  localparam int unsigned BIT_PROT_HI  = 4;
  localparam int unsigned BIT_PROT_LO  = 3;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic       refresh_en;
    logic [2:0] dot_count;
    logic       cell_full;
    logic       hsync;
    logic       vunblank;
    logic       vsync_n;
    logic       phi2;
    logic       read_mem;
    logic       ready;
  } clb_timing_t;

  typedef struct packed {
    logic       buf_sel;
    logic       wr_strobe;
    logic       rd_clock;
    logic       even_inh_n;
    logic       ext_vid_inh_n;
    logic [1:0] prot_bits;
  } clb_bus_out_t;

endpackage : clb_pkg

// ### verilog/clb_video_gen.sv
`timescale 1ns/1ps
`default_nettype none

module clb_video_gen #(
  parameter int unsigned DEPTH = clb_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  // Timing inputs (external pins, synchronised here)
  input  wire clb_pkg::clb_timing_t            timing_in,
  input  wire logic                            present_n,
  input  wire logic                            ctrl_key,
  // Data sources
  input  wire logic [clb_pkg::ENTRY_W-1:0]     data_bus,
  input  wire logic [clb_pkg::ENTRY_W-1:0]     ext_buf_data,
  // Outputs
  output var  clb_pkg::clb_bus_out_t           bus_out,
  output var  logic [clb_pkg::ENTRY_W-1:0]     sel_code,
  output var  logic [clb_pkg::LINE_W-1:0]      scan_line,
  output var  logic                            line10,
  output var  logic                            video
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    clb_pkg::clb_timing_t                 t_s1;
    clb_pkg::clb_timing_t                 t_s2;
    logic [1:0]                           pres_s;
    logic [1:0]                           key_s;
    logic                                 hsync_d;
    logic                                 cell_d;
    logic                                 rd_d;
    logic                                 wr_d;
    logic                                 line10_d;
    logic [clb_pkg::LINE_W-1:0]           line;
    logic                                 carry;
    logic                                 buf_sel;
    logic [DEPTH-1:0][clb_pkg::ENTRY_W-1:0] lbuf;
    logic [clb_pkg::ENTRY_W-1:0]          code;
    logic [clb_pkg::SHIFT_W-1:0]          shreg;
    clb_pkg::clb_bus_out_t                bo;
  } clb_state_t;

  clb_state_t st;
  clb_state_t next_st;

  // ----------------------------------------
  // Dot pattern lookup
  // ----------------------------------------
  // Synthetic glyph set: real font contents are outside this block, so a
  // deterministic pattern per code and line stands in for the mask ROM.
  // Lines 7 to 9 stay dark, which leaves a gap between character rows.
  function automatic logic [clb_pkg::PAT_W-1:0] clb_glyph(
    input logic [clb_pkg::CODE_W-1:0] c,
    input logic [clb_pkg::LINE_W-1:0] l
  );
    logic [clb_pkg::PAT_W-1:0] p;
    p = 7'h00;
    case (l)
      4'h0: begin
        p = c;
      end
      4'h1: begin
        p = c ^ 7'h11;
      end
      4'h2: begin
        p = c ^ 7'h22;
      end
      4'h3: begin
        p = c ^ 7'h33;
      end
      4'h4: begin
        p = c ^ 7'h44;
      end
      4'h5: begin
        p = c ^ 7'h55;
      end
      4'h6: begin
        p = c ^ 7'h66;
      end
      default: begin
        p = 7'h00;
      end
    endcase
    return p;
  endfunction

  // ----------------------------------------
  // Combinational helpers
  // ----------------------------------------
  logic [clb_pkg::PAT_W-1:0]              pattern;
  logic                                   load_now;
  logic                                   shift_clk;
  logic                                   wr_sel;
  logic                                   rd_rise;
  logic                                   wr_rise;
  logic                                   hs_rise;
  logic                                   carry_fall;
  logic                                   printable;
  logic [DEPTH-1:0][clb_pkg::ENTRY_W-1:0] lbuf_step;

  // ----------------------------------------
  // Line buffer step, one slice per entry
  // ----------------------------------------
  // The top entry takes either the bus code or the output entry; every
  // other entry takes its upper neighbour, so a read step is one circular move.
  for (genvar gi = 0; gi < DEPTH; gi++) begin : g_step
    if (gi == DEPTH - 1) begin : g_top
      assign lbuf_step[gi] = wr_sel ? data_bus : st.lbuf[0];
    end else begin : g_mid
      assign lbuf_step[gi] = st.lbuf[gi + 1];
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st   = st;
    shift_clk = 1'b0;
    printable = 1'b0;

    // ----------------------------------------
    // Pin synchronisers and edge detectors
    // ----------------------------------------
    // Pin inputs pass two flops before use; only the second stage is read
    next_st.t_s1   = timing_in;
    next_st.t_s2   = st.t_s1;
    next_st.pres_s = {st.pres_s[0], present_n};
    next_st.key_s  = {st.key_s[0], ctrl_key};

    // Delayed copies rest low after reset, the idle level of every strobe,
    // so no false edge follows reset
    next_st.hsync_d  = st.t_s2.hsync;
    next_st.cell_d   = st.t_s2.cell_full;
    next_st.rd_d     = st.bo.rd_clock;
    next_st.wr_d     = st.bo.wr_strobe;
    next_st.line10_d = st.carry;

    rd_rise    = st.bo.rd_clock && !st.rd_d;
    wr_rise    = st.bo.wr_strobe && !st.wr_d;
    hs_rise    = st.t_s2.hsync && !st.hsync_d;
    carry_fall = st.line10_d && !st.carry;
    load_now   = st.t_s2.cell_full && !st.cell_d;
    wr_sel     = st.buf_sel;
    pattern    = clb_glyph(st.code[clb_pkg::CODE_W-1:0], st.line);

    // ----------------------------------------
    // Line buffer controls
    // ----------------------------------------
    next_st.bo.rd_clock = st.t_s2.refresh_en
                          && (st.t_s2.dot_count >= clb_pkg::DOT_RD_LO)
                          && (st.t_s2.dot_count <= clb_pkg::DOT_RD_HI);
    next_st.bo.wr_strobe = st.t_s2.read_mem
                           && st.t_s2.ready
                           && st.t_s2.phi2;

    // ----------------------------------------
    // Line buffer shifting
    // ----------------------------------------
    // Only strobe rising edges shift, so a strobe held for several clocks
    // still moves the buffer by exactly one entry
    if (rd_rise && !wr_sel) begin
      shift_clk = 1'b1;
    end
    if (wr_rise && wr_sel) begin
      shift_clk = 1'b1;
    end
    if (shift_clk) begin
      next_st.lbuf = lbuf_step;
    end

    // ----------------------------------------
    // Row multiplexer
    // ----------------------------------------
    // The output entry is taken before this cycle's shift moves it away
    if (rd_rise) begin
      if (st.buf_sel) begin
        next_st.code = ext_buf_data;
      end else begin
        next_st.code = st.lbuf[0];
      end
    end
    // Taken from the new code so the bus bits change together with sel_code
    next_st.bo.prot_bits = {next_st.code[clb_pkg::BIT_PROT_HI],
                            next_st.code[clb_pkg::BIT_PROT_LO]};

    // ----------------------------------------
    // Scan line ring counter
    // ----------------------------------------
    if (!st.t_s2.vsync_n) begin
      next_st.line = clb_pkg::LINE_FIRST;
    end else if (st.t_s2.vunblank && hs_rise) begin
      if (st.carry) begin
        next_st.line = clb_pkg::LINE_FIRST;
      end else begin
        next_st.line = st.line + 4'h1;
      end
    end
    // Holds when unblank is low, unless vsync_n is low and clears the line
    next_st.carry = (next_st.line == clb_pkg::LINE_LAST);

    // ----------------------------------------
    // Buffer select
    // ----------------------------------------
    // Keeps alternating regardless of presence, so the local buffer is still
    // written during the rows that an absent module would have shown
    if (!st.t_s2.vunblank) begin
      next_st.buf_sel = 1'b0;
    end else if (carry_fall) begin
      next_st.buf_sel = !st.buf_sel;
    end
    next_st.bo.buf_sel = st.buf_sel;

    // ----------------------------------------
    // Presence inhibits
    // ----------------------------------------
    next_st.bo.even_inh_n    = !st.pres_s[1];
    next_st.bo.ext_vid_inh_n = !(st.pres_s[1] && st.buf_sel);

    // ----------------------------------------
    // Dot shifter
    // ----------------------------------------
    // The load uses the code latched for the previous cell: the shifter
    // runs one cell behind the multiplexer, because the read clock is registered once more than the load
    printable = st.code[clb_pkg::BIT_PRINT_LO]
                || st.code[clb_pkg::BIT_PRINT_HI]
                || st.key_s[1];
    if (load_now) begin
      if (printable) begin
        next_st.shreg = {pattern, 1'b0};
      end else begin
        next_st.shreg = 8'h00;
      end
    end else begin
      next_st.shreg = {st.shreg[clb_pkg::SHIFT_W-2:0], 1'b0};
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus_out   = st.bo;
  assign sel_code  = st.code;
  assign scan_line = st.line;
  assign line10    = st.carry;
  assign video     = st.shreg[clb_pkg::SHIFT_W-1];

endmodule // clb_video_gen

`default_nettype wire

// ### testbench/clb_video_gen_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module clb_video_gen_asserts (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  // Watched ports
  input wire clb_pkg::clb_timing_t timing_in,
  input wire logic                 present_n,
  input wire clb_pkg::clb_bus_out_t bus_out,
  input wire logic [7:0]           sel_code,
  input wire logic [3:0]           scan_line,
  input wire logic                 line10
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----
  // Pin conditions reach the strobes three cycles later
  // ----
  a_wr_strobe_cond: assert property ($past(rst_n, 4) |-> bus_out.wr_strobe == $past(
    timing_in.read_mem & timing_in.ready & timing_in.phi2, 3)) else $error("bad write strobe");
  a_rd_clock_cond: assert property ($past(rst_n, 4) |-> bus_out.rd_clock == $past(
    timing_in.refresh_en & (timing_in.dot_count >= 3'h2), 3)) else $error("bad read clock");
  a_even_inhibit: assert property ($past(rst_n, 4) && $past(present_n, 3)
    |-> !bus_out.even_inh_n) else $error("even inhibit not low");
  a_ext_vid_inhibit: assert property (bus_out.buf_sel && $past(bus_out.buf_sel)
    && $past(present_n, 3) && $past(present_n, 4) |-> !bus_out.ext_vid_inh_n)
    else $error("video inhibit not low");
  a_line_ring: assert property (scan_line <= 4'h9) else $error("line count out of ring");
  a_tenth_carry: assert property (line10 == (scan_line == 4'h9)) else $error("bad carry");
  a_line_step: assert property ($changed(scan_line) && scan_line != 4'h0
    |-> scan_line == $past(scan_line) + 4'h1) else $error("line count skipped");
  a_blank_hold: assert property ($past(rst_n, 5) && !$past(timing_in.vunblank, 3)
    && !$past(timing_in.vunblank, 4) |-> !(scan_line > $past(scan_line)))
    else $error("counted while blanked");
  a_blank_sel_clear: assert property ($past(rst_n, 5) && !$past(timing_in.vunblank, 3)
    && !$past(timing_in.vunblank, 4) |-> !bus_out.buf_sel) else $error("select not clear");
  a_prot_bits: assert property (bus_out.prot_bits == sel_code[4:3])
    else $error("bad protect bits");
endmodule // clb_video_gen_asserts
bind clb_video_gen clb_video_gen_asserts chk_i (.clk_sys, .rst_n, .timing_in, .present_n,
  .bus_out, .sel_code, .scan_line, .line10);
`default_nettype wire

// ### testbench/clb_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module clb_ext_model (
  // Clock and fitting
  input  wire logic                  clk_sys,
  input  wire logic                  fitted,
  // Strobes from the block
  input  wire clb_pkg::clb_bus_out_t bus_out,
  // Far-side pins
  output logic                       present_n,
  output logic [7:0]                 ext_buf_data
);
  logic [3:0] cnt = 4'h0;
  logic       rd_q = 1'b0;
  assign present_n = !fitted;
  // Absent module leaves the data lines floating high
  assign ext_buf_data = fitted ? {4'hA, cnt} : 8'hFF;
  // Advance on the falling read clock so the latched value is never torn
  always @(posedge clk_sys) begin
    rd_q <= bus_out.rd_clock;
    if (rd_q && !bus_out.rd_clock && bus_out.buf_sel) cnt <= cnt + 4'h1;
  end
endmodule // clb_ext_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk_sys, rst_n, ctrl_key, fitted, present_n, line10, video, rd_q;
  clb_pkg::clb_timing_t  tm;
  clb_pkg::clb_bus_out_t bus_out;
  logic [7:0]            data_bus, ext_buf_data, sel_code, code [4], exp_q [$];
  logic [3:0]            scan_line;
  int                    n_errors = 0, comparisons = 0;
  logic [7:0]            vid_sh;
  always @(posedge clk_sys) vid_sh <= {vid_sh[6:0], video};
  // Expected dot byte: synthetic glyph, lit only for printable codes or key
  function automatic logic [7:0] exp_dots(input logic [7:0] c, input int l);
    logic [6:0] p;
    p = (l > 6) ? 7'h00 : (c[6:0] ^ {l[2:0], l[3:0]});
    return (c[5] || c[6] || ctrl_key) ? {p, 1'b0} : 8'h00;
  endfunction
  clb_video_gen #(.DEPTH(4)) clb_video_gen_i (.clk_sys, .rst_n, .timing_in(tm), .present_n,
    .ctrl_key, .data_bus, .ext_buf_data, .bus_out, .sel_code, .scan_line, .line10, .video);
  clb_ext_model clb_ext_model_i (.clk_sys, .fitted, .bus_out, .present_n, .ext_buf_data);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ----
  // Checks and operations
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Kind 0 reads a cell, 1 writes a code, 2 ends a scan line
  task automatic op(input int k, input logic [7:0] c);
    @(posedge clk_sys);
    if (k == 1) data_bus <= c;
    tm.hsync <= k == 2;
    tm.refresh_en <= k == 0;
    tm.cell_full <= k == 0;
    tm.read_mem <= k == 1;
    repeat (2) @(posedge clk_sys);
    tm.hsync <= 1'b0;
    tm.refresh_en <= 1'b0;
    tm.cell_full <= 1'b0;
    tm.read_mem <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  // Each finished read takes the oldest noted code
  always @(posedge clk_sys) begin
    rd_q <= bus_out.rd_clock;
    if (rd_q && !bus_out.rd_clock && exp_q.size() > 0) chk(sel_code, exp_q.pop_front());
  end
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h4329));
    tm = '0;
    tm.dot_count = 3'h2;
    tm.ready = 1'b1;
    tm.phi2 = 1'b1;
    tm.vsync_n = 1'b1;
    tm.vunblank = 1'b1;
    rst_n = 1'b0;
    fitted = 1'b1;
    data_bus = 8'h00;
    ctrl_key = 1'b0;
    for (int i = 0; i < 4; i++) code[i] = 8'($urandom) & 8'hFC | 8'(i);
    code[0][6:5] = 2'b00;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    ctrl_key <= 1'($urandom);
    // Row 0 local, row 1 fills the local buffer, row 2 recirculates it
    for (int r = 0; r < 3; r++) begin
      for (int l = 0; l < 10; l++) begin
        if (r == 1 && l < 4) op(1, code[l]);
        if (r == 2) exp_q.push_back(code[l % 4]);
        op(0, 8'h00);
        if (r == 2 && l > 0) begin
          repeat (4) @(posedge clk_sys);
          chk(vid_sh, exp_dots(code[(l - 1) % 4], l));
        end
        op(2, 8'h00);
        chk({4'h0, scan_line}, 8'((l + 1) % 10));
      end
      chk({7'h0, bus_out.buf_sel}, 8'((r + 1) % 2));
    end
    fitted <= 1'b0;
    op(2, 8'h00);
    tm.vunblank <= 1'b0;
    op(2, 8'h00);
    chk({4'h0, scan_line}, 8'h01);
    chk({7'h0, bus_out.buf_sel}, 8'h00);
    tm.vsync_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({4'h0, scan_line}, 8'h00);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
